// File: shared/pif_pkg.sv
// Operation
// - events set flags regardless of any enable
// - flag one means pending, zero means none
// - every implemented flag resets to zero
// - register a bit 7 gate event, read/write
// - register a bit 6 conversion done, read/write
// - register a bit 5 serial receive, read-only
// - register a bit 4 serial transmit, read-only
// - register a bit 3 sync port one, read/write
// - register a bit 2 capture/compare one, read/write
// - register a bit 1 period match, read/write
// - register a bit 0 timer overflow, read/write
// - register b bit 6 comparator two, read/write
// - register b bit 5 comparator one, read/write
// - register b bit 4 nonvolatile write done
// - register b bit 3 port one collision
// - register b bits 2-1 read zero, ignore writes
// - register b bit 0 capture/compare two, large variant
package pif_pkg;

    localparam int          AXI_AW          = 4;
    localparam int          AXI_DW          = 32;
    localparam logic [3:0]  OFS_FLAGS_A     = 4'h0;
    localparam logic [3:0]  OFS_FLAGS_B     = 4'h4;

    localparam logic [7:0]  FLAGS_RESET     = 8'h00;
    localparam logic [7:0]  FLAGS_A_WMASK   = 8'hCF;
    localparam logic [7:0]  FLAGS_B_IMPL_LG = 8'hF9;
    localparam logic [7:0]  FLAGS_B_IMPL_SM = 8'hF8;

    localparam int          BIT_GATE_EVENT  = 7;
    localparam int          BIT_CONV_DONE   = 6;
    localparam int          BIT_SERIAL_RX   = 5;
    localparam int          BIT_SERIAL_TX   = 4;
    localparam int          BIT_SYNC_ONE    = 3;
    localparam int          BIT_CAPCOMP_ONE = 2;
    localparam int          BIT_PERIOD      = 1;
    localparam int          BIT_OVERFLOW    = 0;
    localparam int          BIT_OSC_FAIL    = 7;
    localparam int          BIT_CMP_TWO     = 6;
    localparam int          BIT_CMP_ONE     = 5;
    localparam int          BIT_NV_DONE     = 4;
    localparam int          BIT_COLLISION   = 3;
    localparam int          BIT_CAPCOMP_TWO = 0;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef struct packed {
        logic gate_event_flag;
        logic conversion_done_flag;
        logic serial_rx_flag;
        logic serial_tx_flag;
        logic sync_port_one_flag;
        logic capcomp_one_flag;
        logic period_match_flag;
        logic overflow_flag;
    } pif_flags_a_t;

    typedef struct packed {
        logic       osc_fail_flag;
        logic       comparator_two_flag;
        logic       comparator_one_flag;
        logic       nv_write_done_flag;
        logic       port_one_collision_flag;
        logic [1:0] unused;
        logic       capcomp_two_flag;
    } pif_flags_b_t;

endpackage

// File: hw/pif_flag_regs.sv
// peripheral interrupt request flag registers behind an axi4-lite slave
`timescale 1ns/1ps
module pif_flag_regs
    import pif_pkg::*;
#(
    parameter int HAS_CAPCOMP_TWO = 1
)(
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire pif_flags_a_t        evt_a,
    input  wire pif_flags_b_t        evt_b,
    output logic [7:0]               flags_a,
    output logic [7:0]               flags_b,
    input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [AXI_DW-1:0]   s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [AXI_AW-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [AXI_DW-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    // only the small and large variants exist
    if (HAS_CAPCOMP_TWO != 0 && HAS_CAPCOMP_TWO != 1)
    begin : g_bad_variant
        $error("HAS_CAPCOMP_TWO must be 0 or 1");
    end

    // flags and replies travel in a full bus word
    if (AXI_DW != 32)
    begin : g_bad_width
        $error("register bus data must be 32 bits wide");
    end

    // both register offsets must fit the address
    if (AXI_AW < 3)
    begin : g_bad_addr
        $error("register bus address needs at least 3 bits");
    end

    localparam logic [7:0] FLAGS_B_WMASK = (HAS_CAPCOMP_TWO == 1) ? FLAGS_B_IMPL_LG
                                                                  : FLAGS_B_IMPL_SM;

    logic [7:0]        flags_a_r;
    logic [7:0]        flags_b_r;
    logic              aw_full_r;
    logic              w_full_r;
    logic [AXI_AW-1:0] aw_addr_r;
    logic [7:0]        w_byte_r;
    logic              w_lane0_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [AXI_DW-1:0] rdata_r;
    logic              aw_full_nxt;
    logic              w_full_nxt;
    logic              commit;
    logic              wr_a;
    logic              wr_b;
    logic [7:0]        flags_a_nxt;
    logic [7:0]        flags_b_nxt;
    // handshake strobes and decodes
    logic              aw_take;
    logic              w_take;
    logic              ar_take;
    logic              r_done;
    logic              b_done;
    logic              wr_addr_ok;
    logic              rd_sel_a;
    logic              rd_sel_b;
    logic              rd_addr_ok;
    logic [7:0]        rd_byte;

    // write takes effect once address and data are both held
    assign commit     = aw_full_r && w_full_r && !bvalid_r;
    assign aw_take    = s_axi_awvalid && awready_r;
    assign w_take     = s_axi_wvalid && wready_r;
    assign ar_take    = s_axi_arvalid && arready_r;
    assign r_done     = rvalid_r && s_axi_rready;
    assign b_done     = bvalid_r && s_axi_bready;
    assign wr_addr_ok = (aw_addr_r == OFS_FLAGS_A) || (aw_addr_r == OFS_FLAGS_B);

    // a write with lane 0 off is answered but changes nothing
    always_comb
    begin
        wr_a = 1'b0;
        wr_b = 1'b0;
        if (commit && w_lane0_r)
        begin
            wr_a = (aw_addr_r == OFS_FLAGS_A);
            wr_b = (aw_addr_r == OFS_FLAGS_B);
        end
    end

    // address slot empties only when the write commits
    always_comb
    begin
        aw_full_nxt = aw_full_r;
        if (commit)
        begin
            aw_full_nxt = 1'b0;
        end
        else if (aw_take)
        begin
            aw_full_nxt = 1'b1;
        end
    end

    // data slot follows the same rule
    always_comb
    begin
        w_full_nxt = w_full_r;
        if (commit)
        begin
            w_full_nxt = 1'b0;
        end
        else if (w_take)
        begin
            w_full_nxt = 1'b1;
        end
    end

    // read mux; unmapped offsets return zero
    always_comb
    begin
        rd_sel_a   = (s_axi_araddr == OFS_FLAGS_A);
        rd_sel_b   = (s_axi_araddr == OFS_FLAGS_B);
        rd_addr_ok = rd_sel_a || rd_sel_b;
        rd_byte    = 8'h00;
        if (rd_sel_a)
        begin
            rd_byte = flags_a_r;
        end
        else if (rd_sel_b)
        begin
            rd_byte = flags_b_r;
        end
    end

    // one cell per flag bit; a set arriving with a software clear wins
    for (genvar i = 0; i < 8; i++)
    begin : g_flag_a
        if (FLAGS_A_WMASK[i])
        begin : g_rw
            assign flags_a_nxt[i] = (wr_a ? w_byte_r[i] : flags_a_r[i]) | evt_a[i];
        end
        else
        begin : g_mirror
            // serial flags mirror the serial unit's pending levels only
            assign flags_a_nxt[i] = evt_a[i];
        end
    end

    for (genvar j = 0; j < 8; j++)
    begin : g_flag_b
        if (FLAGS_B_WMASK[j])
        begin : g_rw
            assign flags_b_nxt[j] = (wr_b ? w_byte_r[j] : flags_b_r[j]) | evt_b[j];
        end
        else
        begin : g_unused
            // unimplemented bits never hold a value
            assign flags_b_nxt[j] = 1'b0;
        end
    end

    // register a
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            flags_a_r <= FLAGS_RESET;
        end
        else
        begin
            flags_a_r <= flags_a_nxt;
        end
    end

    // register b
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            flags_b_r <= FLAGS_RESET;
        end
        else
        begin
            flags_b_r <= flags_b_nxt;
        end
    end

    // address slot and its ready
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_full_r <= 1'b0;
            awready_r <= 1'b0;
        end
        else
        begin
            aw_full_r <= aw_full_nxt;
            awready_r <= !aw_full_nxt;
        end
    end

    // data slot and its ready
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            w_full_r <= 1'b0;
            wready_r <= 1'b0;
        end
        else
        begin
            w_full_r <= w_full_nxt;
            wready_r <= !w_full_nxt;
        end
    end

    // captured write address
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_addr_r <= '0;
        end
        else if (aw_take)
        begin
            aw_addr_r <= s_axi_awaddr;
        end
    end

    // only the low data byte reaches the flags
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            w_byte_r <= 8'h00;
        end
        else if (w_take)
        begin
            w_byte_r <= s_axi_wdata[7:0];
        end
    end

    // lane 0 strobe of the captured data
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            w_lane0_r <= 1'b0;
        end
        else if (w_take)
        begin
            w_lane0_r <= s_axi_wstrb[0];
        end
    end

    // write response stands until bready
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            bvalid_r <= 1'b0;
        end
        else if (commit)
        begin
            bvalid_r <= 1'b1;
        end
        else if (b_done)
        begin
            bvalid_r <= 1'b0;
        end
    end

    // unmapped writes answer with an error
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            bresp_r <= RESP_OKAY;
        end
        else if (commit)
        begin
            bresp_r <= wr_addr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // next read address only once the answer is taken
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            arready_r <= 1'b0;
        end
        else if (ar_take)
        begin
            arready_r <= 1'b0;
        end
        else if (r_done || !rvalid_r)
        begin
            arready_r <= 1'b1;
        end
    end

    // read answer stands until rready
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rvalid_r <= 1'b0;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
        end
        else if (r_done)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // unmapped reads answer with an error
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rresp_r <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rresp_r <= rd_addr_ok ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // read data; upper bytes always zero
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else if (ar_take)
        begin
            rdata_r <= {24'h00_0000, rd_byte};
        end
    end

    assign flags_a       = flags_a_r;
    assign flags_b       = flags_b_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

endmodule

// File: bench/pif_flag_regs_monitor.sv
// concurrent checks on the flag register block ports
`timescale 1ns/1ps
module pif_flag_regs_monitor
    import pif_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire pif_flags_a_t      evt_a,
    input wire pif_flags_b_t      evt_b,
    input wire logic [7:0]        flags_a,
    input wire logic [7:0]        flags_b,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [AXI_DW-1:0] s_axi_rdata
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_evt_sets_a: assert property (
        (evt_a & 8'hCF) != 8'h00 |=> (flags_a & $past(evt_a) & 8'hCF) == ($past(evt_a) & 8'hCF))
        else $error("flag a not set by event");
    a_evt_sets_b: assert property (
        (evt_b & 8'hF9) != 8'h00 |=> (flags_b & $past(evt_b) & 8'hF9) == ($past(evt_b) & 8'hF9))
        else $error("flag b not set by event");
    a_serial_mirror: assert property (1'b1 |=> flags_a[5:4] == $past(evt_a[5:4]))
        else $error("serial flags do not follow peripheral");
    a_unused_zero: assert property (flags_b[2:1] == 2'b00)
        else $error("unimplemented bits set");
    a_reset_clear: assert property ($fell(rst) |-> flags_a == 8'h00 && flags_b == 8'h00)
        else $error("flags not clear after reset");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rvalid_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_ar_blocked: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
        else $error("read address taken too soon");
    c_event: cover property ((evt_a & 8'hCF) != 8'h00);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// File: bench/pif_periph_model.sv
// peripheral side: turns bench requests into event lines
`timescale 1ns/1ps
module pif_periph_model
    import pif_pkg::*;
(
    input wire logic         ref_clk,
    input wire pif_flags_a_t req_a,
    input wire pif_flags_b_t req_b,
    output pif_flags_a_t     evt_a,
    output pif_flags_b_t     evt_b
);
    // events are raised with no regard to any enable
    always_ff @(posedge ref_clk)
    begin
        evt_a <= req_a;
        evt_b <= req_b;
    end
endmodule

// File: bench/peripheral_irq_flag_regs_bench.sv
// self-checking bench for the peripheral flag registers
`timescale 1ns/1ps
module peripheral_irq_flag_regs_bench
    import pif_pkg::*;
;
    logic         ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic         s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic         s_axi_rvalid;
    logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0]  s_axi_wdata, s_axi_rdata, rdv;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0]   flags_a, flags_b;
    pif_flags_a_t req_a, evt_a;
    pif_flags_b_t req_b, evt_b;
    int           n_errors, check_count;
    pif_periph_model u_per (.ref_clk, .req_a, .req_b, .evt_a, .evt_b);
    pif_flag_regs dut (.ref_clk, .rst, .evt_a, .evt_b, .flags_a, .flags_b, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one register transfer; we selects write or read
    task bus(input logic we, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= we;
        s_axi_wvalid <= we;
        s_axi_bready <= we;
        s_axi_arvalid <= !we;
        s_axi_rready <= !we;
        do
        begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while ((we ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        rdv = s_axi_rdata;
        rsp = we ? s_axi_bresp : s_axi_rresp;
    endtask
    task pulse(input logic [7:0] a, input logic [7:0] b);
        @(posedge ref_clk);
        req_a <= a;
        req_b <= b;
        @(posedge ref_clk);
        req_a <= 8'h00;
        req_b <= 8'h00;
    endtask
    task t_reset_map;
        bus(1'b0, OFS_FLAGS_B, 8'h00);
        chk(rdv, 32'h0000_0000);
        bus(1'b0, 4'h8, 8'h00);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    endtask
    task t_events_a;
        for (int i = 0; i < 8; i++)
        begin
            if (i == 4 || i == 5) continue;
            pulse(8'h01 << i, 8'h00);
            bus(1'b0, OFS_FLAGS_A, 8'h00);
            chk(rdv, 32'h0000_0001 << i);
            bus(1'b1, OFS_FLAGS_A, 8'h00);
            bus(1'b0, OFS_FLAGS_A, 8'h00);
            chk(rdv, 32'h0000_0000);
        end
    endtask
    task t_writes;
        bus(1'b1, OFS_FLAGS_A, 8'hFF);
        bus(1'b0, OFS_FLAGS_A, 8'h00);
        chk(rdv, 32'h0000_00CF);
        bus(1'b1, OFS_FLAGS_B, 8'hFF);
        bus(1'b0, OFS_FLAGS_B, 8'h00);
        chk(rdv, 32'h0000_00F9);
        s_axi_wstrb <= 4'h0;
        bus(1'b1, OFS_FLAGS_B, 8'h00);
        s_axi_wstrb <= 4'hF;
        chk({30'h0, rsp}, {30'h0, RESP_OKAY});
        bus(1'b0, OFS_FLAGS_B, 8'h00);
        chk(rdv, 32'h0000_00F9);
        bus(1'b1, OFS_FLAGS_B, 8'h00);
        pulse(8'h00, 8'hFF);
        bus(1'b0, OFS_FLAGS_B, 8'h00);
        chk(rdv, 32'h0000_00F9);
    endtask
    task t_serial;
        @(posedge ref_clk);
        req_a <= 8'h30;
        bus(1'b1, OFS_FLAGS_A, 8'h00);
        bus(1'b0, OFS_FLAGS_A, 8'h00);
        chk(rdv, 32'h0000_0030);
        @(posedge ref_clk);
        req_a <= 8'h00;
        @(posedge ref_clk);
        bus(1'b0, OFS_FLAGS_A, 8'h00);
        chk(rdv, 32'h0000_0000);
    endtask
    task t_midreset;
        pulse(8'hCF, 8'hF9);
        repeat (2) @(posedge ref_clk);
        chk({flags_a, flags_b}, 16'hCFF9);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({flags_a, flags_b}, 16'h0000);
        rst <= 1'b0;
        bus(1'b0, OFS_FLAGS_A, 8'h00);
        chk(rdv, 32'h0000_0000);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h3F;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, req_a, req_b} = '0;
        s_axi_wstrb = 4'hF;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset_map;
        t_events_a;
        t_writes;
        t_serial;
        t_midreset;
        summarize;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        summarize;
    end
endmodule
bind pif_flag_regs pif_flag_regs_monitor u_mon (.ref_clk, .rst, .evt_a, .evt_b, .flags_a,
    .flags_b, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata);
